// File: logic/lsrd_top.sv
// Line status, reset delay and supply threshold register bank with APB slave
`timescale 1ns/1ns
module lsrd_top
  import lsrd_pkg::*;
#(
  parameter int QUAL_ACT_US   = 50,
  parameter int QUAL_INACT_US = 50,
  parameter int DELAY_SCALE   = 1
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        wire_network_activity,
  input  wire logic        switch_input_pin,
  input  wire logic        lin_pin,
  input  wire logic        network_status_pin,
  input  wire logic        reset_pin_in,
  input  wire logic        supply_ok,
  input  wire logic        wire_network_wake_cause,
  input  wire logic        super_above,
  input  wire logic        critical_below,
  input  wire logic        low_below,
  output logic             reset_out_n,
  output logic [1:0]       super_trip_select,
  output logic [1:0]       critical_trip_select,
  output logic [1:0]       low_trip_select,
  output logic             irq
);
  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  localparam int NSYNC = 9;
  // Active-low pins idle high; zero here would fake a reset-pin indication
  // and start the wake timers straight out of reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = 9'h00F;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] raw_in;
  assign raw_in = {low_below, critical_below, super_above, wire_network_wake_cause, supply_ok,
                   reset_pin_in, network_status_pin, lin_pin, switch_input_pin};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= SYNC_IDLE;
      sync2_reg <= SYNC_IDLE;
    end
    else
    begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  logic sw_s;
  logic lin_s;
  logic stat_s;
  logic rstpin_s;
  logic supply_s;
  logic netwake_s;
  logic [2:0] region_s;
  assign sw_s      = sync2_reg[0];
  assign lin_s     = sync2_reg[1];
  assign stat_s    = sync2_reg[2];
  assign rstpin_s  = sync2_reg[3];
  assign supply_s  = sync2_reg[4];
  assign netwake_s = sync2_reg[5];
  assign region_s  = sync2_reg[8:6];

  logic net1_reg;
  logic net2_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      net1_reg <= 1'b0;
      net2_reg <= 1'b0;
    end
    else
    begin
      net1_reg <= wire_network_activity;
      net2_reg <= net1_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Qualification timers
  // ---------------------------------------------------------------------------
  localparam int ACT_CYC   = (QUAL_ACT_US * LSRD_CLK_KHZ) / 1000;
  localparam int INACT_CYC = (QUAL_INACT_US * LSRD_CLK_KHZ) / 1000;
  localparam int NQ        = 4;

  // Active level per pin: network activity high, the three wake pins low
  logic [NQ-1:0] qual_active;
  logic [NQ-1:0] qual_reg;
  assign qual_active = {net2_reg, ~sw_s, ~lin_s, ~stat_s};

  genvar g;
  generate
    for (g = 0; g < NQ; g++)
    begin : g_qual
      lsrd_qual
      #(
        .ACT_CYC   (ACT_CYC),
        .INACT_CYC (INACT_CYC)
      )
      u_qual
      (
        .pclk     (pclk),
        .presetn  (presetn),
        .level_in (qual_active[g]),
        .qual_out (qual_reg[g])
      );
    end
  endgenerate

  logic [7:0] line_status;
  always_comb
  begin
    line_status = '0;
    line_status[LSRD_BIT_RESET]  = ~rstpin_s;
    line_status[LSRD_BIT_NET]    = qual_reg[3];
    line_status[LSRD_BIT_SWITCH] = qual_reg[2];
    line_status[LSRD_BIT_LIN]    = qual_reg[1];
    line_status[LSRD_BIT_STATUS] = qual_reg[0];
  end

  // ---------------------------------------------------------------------------
  // Reset generator
  // ---------------------------------------------------------------------------
  logic [2:0] delay_reg;
  logic [2:0] netdly_reg;
  logic [5:0] thresh_reg;
  logic [31:0] rcnt_reg;
  logic [31:0] delay_cyc;
  logic [2:0]  sel_code;

  assign sel_code  = netwake_s ? netdly_reg : delay_reg;
  assign delay_cyc = 32'((LSRD_DELAY_US[sel_code] * (LSRD_CLK_KHZ / 1000)) / DELAY_SCALE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rcnt_reg    <= '0;
      reset_out_n <= 1'b0;
    end
    else if (!supply_s)
    begin
      rcnt_reg    <= '0;
      reset_out_n <= 1'b0;
    end
    else if (!reset_out_n)
    begin
      if (rcnt_reg >= delay_cyc - 32'd1)
      begin
        reset_out_n <= 1'b1;
      end
      else
      begin
        rcnt_reg <= rcnt_reg + 32'd1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Threshold outputs and region
  // ---------------------------------------------------------------------------
  assign super_trip_select    = thresh_reg[5:4];
  assign critical_trip_select = thresh_reg[3:2];
  assign low_trip_select      = thresh_reg[1:0];

  // All clear means normal region
  logic [7:0] region_status;
  assign region_status = {5'h0, region_s[0], region_s[1], region_s[2]};

  // ---------------------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------------------
  logic [LSRD_IRQ_W-1:0] irq_st_reg;
  logic [LSRD_IRQ_W-1:0] irq_mask_reg;
  logic [NQ-1:0]         qual_prev_reg;
  logic [2:0]            region_prev_reg;
  logic [LSRD_IRQ_W-1:0] irq_evt;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      qual_prev_reg   <= '0;
      region_prev_reg <= '0;
    end
    else
    begin
      qual_prev_reg   <= qual_reg;
      region_prev_reg <= region_s;
    end
  end

  assign irq_evt = {region_s != region_prev_reg, qual_reg ^ qual_prev_reg};

  // ---------------------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------------------
  logic       wr_en;
  logic       rd_en;
  logic [7:0] idx;
  logic       mapped;
  assign idx   = paddr[9:2];
  assign wr_en = psel && penable && pwrite;
  // Read data is captured in setup so it stands through the whole access
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
                  (idx == LSRD_IDX_LINE || idx == LSRD_IDX_DELAY || idx == LSRD_IDX_THRESH ||
                   idx == LSRD_IDX_REGION || idx == LSRD_IDX_IRQST ||
                   idx == LSRD_IDX_IRQMSK || idx == LSRD_IDX_NETDLY);
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      delay_reg    <= LSRD_DELAY_RST;
      netdly_reg   <= LSRD_NETDLY_RST;
      thresh_reg   <= {LSRD_SUPER_RST, LSRD_CRIT_RST, LSRD_LOW_RST};
      irq_mask_reg <= '0;
    end
    else if (wr_en && mapped)
    begin
      case (idx)
        LSRD_IDX_DELAY:  delay_reg    <= pwdata[2:0];
        LSRD_IDX_THRESH: thresh_reg   <= pwdata[5:0];
        LSRD_IDX_IRQMSK: irq_mask_reg <= pwdata[LSRD_IRQ_W-1:0];
        LSRD_IDX_NETDLY: netdly_reg   <= pwdata[2:0];
        default:         ;
      endcase
    end
  end

  // New events win over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_st_reg <= '0;
    end
    else
    begin
      irq_st_reg <= (irq_st_reg & ~((wr_en && idx == LSRD_IDX_IRQST && mapped) ?
                    pwdata[LSRD_IRQ_W-1:0] : '0)) | irq_evt;
    end
  end

  assign irq = |(irq_st_reg & irq_mask_reg);

  // Refused accesses read zero even when the index bits hit a register
  logic [31:0] rd_word;
  always_comb
  begin
    rd_word = '0;
    if (mapped)
    begin
      case (idx)
        LSRD_IDX_LINE:   rd_word = {24'h0000_00, line_status};
        LSRD_IDX_DELAY:  rd_word = {29'h0, delay_reg};
        LSRD_IDX_THRESH: rd_word = {26'h0, thresh_reg};
        LSRD_IDX_REGION: rd_word = {24'h0000_00, region_status};
        LSRD_IDX_IRQST:  rd_word = {27'h0, irq_st_reg};
        LSRD_IDX_IRQMSK: rd_word = {27'h0, irq_mask_reg};
        LSRD_IDX_NETDLY: rd_word = {29'h0, netdly_reg};
        default:         rd_word = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
    end
    else if (rd_en)
    begin
      prdata <= rd_word;
    end
  end
endmodule

// -----------------------------------------------------------------------------
// Qualification timer for one wake input
// -----------------------------------------------------------------------------
module lsrd_qual
  import lsrd_pkg::*;
#(
  parameter int ACT_CYC   = 5000,
  parameter int INACT_CYC = 5000
)
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic level_in,
  output logic      qual_out
);
  localparam int QW = $clog2((ACT_CYC > INACT_CYC ? ACT_CYC : INACT_CYC) + 1);
  logic [QW-1:0] cnt_reg;
  logic [QW-1:0] target;
  // Dwell time depends on which way the bit would move
  assign target = qual_out ? QW'(INACT_CYC) : QW'(ACT_CYC);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg  <= '0;
      qual_out <= 1'b0;
    end
    else if (level_in == qual_out)
    begin
      cnt_reg <= '0;
    end
    else if (cnt_reg >= target - QW'(1))
    begin
      cnt_reg  <= '0;
      qual_out <= level_in;
    end
    else
    begin
      cnt_reg <= cnt_reg + QW'(1);
    end
  end
endmodule

// File: logic/lsrd_pkg.sv
// Package with register map, field layouts, reset values and timing constants
package lsrd_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] LSRD_IDX_LINE   = 8'h02;
  localparam logic [7:0] LSRD_IDX_DELAY  = 8'h03;
  localparam logic [7:0] LSRD_IDX_THRESH = 8'h04;
  localparam logic [7:0] LSRD_IDX_REGION = 8'h10;
  localparam logic [7:0] LSRD_IDX_IRQST  = 8'h11;
  localparam logic [7:0] LSRD_IDX_IRQMSK = 8'h12;
  localparam logic [7:0] LSRD_IDX_NETDLY = 8'h13;

  // ---------------------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------------------
  localparam int LSRD_BIT_RESET  = 5;
  localparam int LSRD_BIT_NET    = 4;
  localparam int LSRD_BIT_SWITCH = 3;
  localparam int LSRD_BIT_LIN    = 2;
  localparam int LSRD_BIT_STATUS = 1;
  localparam logic [2:0] LSRD_DELAY_RST  = 3'h7;
  localparam logic [1:0] LSRD_SUPER_RST  = 2'h2;
  localparam logic [1:0] LSRD_CRIT_RST   = 2'h1;
  localparam logic [1:0] LSRD_LOW_RST    = 2'h1;
  localparam logic [2:0] LSRD_NETDLY_RST = 3'h7;

  // Interrupt status bits: one per qualified pin, one shared by all region changes
  localparam int LSRD_IRQ_W      = 5;
  localparam int LSRD_IRQ_REGION = 4;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int LSRD_CLK_KHZ = 100_000;
  // Delay table in microseconds, index is the delay code
  localparam int LSRD_DELAY_US [8] = '{1200, 2000, 4000, 8000, 12000, 20000, 30000, 45000};
endpackage

// File: test/lsrd_monitor.sv
// Concurrent checks on the register bank ports
`timescale 1ns/1ns
module lsrd_monitor
#(
  parameter int DELAY_SCALE = 1
)
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        supply_ok,
  input wire logic        reset_out_n,
  input wire logic [1:0]  super_trip_select,
  input wire logic [1:0]  critical_trip_select,
  input wire logic [1:0]  low_trip_select,
  input wire logic        irq
);
  localparam int MIN_DLY = 120000 / DELAY_SCALE;
  int          up_cnt;
  logic        acc;
  logic [5:0]  sel;
  assign acc = psel && penable;
  assign sel = {super_trip_select, critical_trip_select, low_trip_select};
  // Supply-good run length, release may never beat the shortest delay
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      up_cnt <= 0;
    else if (!supply_ok)
      up_cnt <= 0;
    else if (up_cnt < MIN_DLY)
      up_cnt <= up_cnt + 1;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_line_rsvd_zero: assert property (acc && !pwrite && paddr == 12'h008 |->
    prdata[31:6] == 0 && !prdata[0]) else $error("line reserved bits set");
  a_bad_addr_err: assert property (acc && paddr[1:0] != 0 |-> pslverr)
    else $error("unaligned access not refused");
  a_trip_only_write: assert property ($changed(sel) |->
    $past(acc && pwrite && paddr == 12'h010)) else $error("trip select moved");
  a_trip_write: assert property (acc && pwrite && paddr == 12'h010 |=>
    sel == $past(pwdata[5:0])) else $error("trip write lost");
  a_trip_readback: assert property (acc && !pwrite && paddr == 12'h010 |->
    prdata == {26'h0, sel}) else $error("trip readback wrong");
  a_supply_low_rst: assert property (!supply_ok |-> ##[0:3] !reset_out_n)
    else $error("reset not driven low");
  a_rst_held_low: assert property (!supply_ok [*3] |=> !reset_out_n)
    else $error("reset released with supply low");
  a_rst_release_delay: assert property ($rose(reset_out_n) |-> up_cnt >= MIN_DLY)
    else $error("reset released early");
  c_err: cover property (acc && pslverr);
  c_release: cover property ($rose(reset_out_n));
  c_irq: cover property ($rose(irq));
endmodule
bind lsrd_top lsrd_monitor #(.DELAY_SCALE(DELAY_SCALE)) u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pslverr(pslverr), .supply_ok(supply_ok), .reset_out_n(reset_out_n),
  .super_trip_select(super_trip_select), .critical_trip_select(critical_trip_select),
  .low_trip_select(low_trip_select), .irq(irq));

// File: test/lsrd_host.sv
// APB host model standing in for the external controller
`timescale 1ns/1ns
module lsrd_host
(
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  int tmo = 0;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20)
      tmo++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge keeps a back-to-back call from driving psel twice at once
    @(posedge pclk);
  endtask
endmodule

// File: test/lsrd_top_test.sv
// Self-checking bench for the register bank
`timescale 1ns/1ns
module lsrd_top_test;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, irq, reset_out_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  act = 4'h0;
  logic [2:0]  region = 3'h0;
  logic        supply_ok = 1'b1;
  logic        wake_net = 1'b0;
  logic [1:0]  sup_sel, crit_sel, low_sel;
  int          miscompares = 0;
  int          checks = 0;
  always #5 pclk = ~pclk;
  lsrd_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  lsrd_top #(.QUAL_ACT_US(1), .QUAL_INACT_US(1), .DELAY_SCALE(1000)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wire_network_activity(act[3]), .switch_input_pin(~act[2]), .lin_pin(~act[1]),
    .network_status_pin(~act[0]), .reset_pin_in(reset_out_n), .supply_ok(supply_ok),
    .wire_network_wake_cause(wake_net), .super_above(region[2]),
    .critical_below(region[1]), .low_below(region[0]), .reset_out_n(reset_out_n),
    .super_trip_select(sup_sel), .critical_trip_select(crit_sel),
    .low_trip_select(low_sel), .irq(irq));
  task automatic close_out;
    miscompares += host.tmo;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v,
                     input logic [31:0] exp, input logic eexp);
    logic [31:0] d;
    logic        e;
    host.xfer(w, a, v, d, e);
    if (host.tmo != 0)
      close_out();
    if (!w)
      chk($sformatf("read %h", a), exp, d);
    chk("pslverr", {31'h0, eexp}, {31'h0, e});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
    bus(1'b0, a, 32'h0000_0000, exp, eexp);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    bus(1'b1, a, v, 32'h0000_0000, 1'b0);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic wait_rel(input int exp);
    int n;
    n = 0;
    while (reset_out_n !== 1'b1 && n < 6000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 6000)
      miscompares++;
    if (n >= 6000)
      close_out();
    chk("release cycles", 32'h1, {31'h0, (n >= exp && n <= exp + 6)});
  endtask
  task automatic t_regs;
    rd(12'h00C, 32'h0000_0007, 1'b0);
    rd(12'h010, 32'h0000_0025, 1'b0);
    wr(12'h008, 32'hFFFF_FFFF);
    rd(12'h008, 32'h0000_0000, 1'b0);
    rd(12'h014, 32'h0000_0000, 1'b1);
    rd(12'h009, 32'h0000_0000, 1'b1);
    rd(12'h00D, 32'h0000_0000, 1'b1);
    rd(12'h40C, 32'h0000_0000, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      wr(12'h010, {24'h0, 2'b11, 2'(i), 2'(i), 2'(i)});
      rd(12'h010, {26'h0, 2'(i), 2'(i), 2'(i)}, 1'b0);
      chk("trip selects", {26'h0, 2'(i), 2'(i), 2'(i)}, {26'h0, sup_sel, crit_sel, low_sel});
    end
    for (int k = 0; k < 4; k++)
    begin
      region <= (k < 3) ? 3'(1 << k) : 3'h0;
      cyc(4);
      rd(12'h040, (k < 3) ? 32'(1 << k) : 32'h0, 1'b0);
    end
    $display("test registers done");
  endtask
  task automatic t_pins;
    for (int k = 0; k < 4; k++)
    begin
      act <= 4'(1 << k);
      cyc(50);
      act <= 4'h0;
      cyc(150);
      rd(12'h008, 32'h0000_0000, 1'b0);
      act <= 4'(1 << k);
      cyc(150);
      rd(12'h008, 32'(2 << k), 1'b0);
      act <= 4'h0;
      cyc(150);
      rd(12'h008, 32'h0000_0000, 1'b0);
    end
    $display("test pins done");
  endtask
  task automatic t_irq;
    wr(12'h048, 32'h0000_0000);
    wr(12'h044, 32'h0000_001F);
    act <= 4'h2;
    cyc(150);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(12'h044, 32'h0000_0002, 1'b0);
    wr(12'h048, 32'h0000_0002);
    chk("irq", 32'h1, {31'h0, irq});
    wr(12'h044, 32'h0000_0002);
    chk("irq cleared", 32'h0, {31'h0, irq});
    act <= 4'h0;
    cyc(150);
    chk("irq", 32'h1, {31'h0, irq});
    wr(12'h044, 32'h0000_0002);
    $display("test irq done");
  endtask
  task automatic t_delay;
    wr(12'h00C, 32'h0000_0000);
    supply_ok <= 1'b0;
    cyc(4);
    chk("reset_out_n", 32'h0, {31'h0, reset_out_n});
    // Reset pin level needs two sync edges before the line bit follows
    cyc(2);
    rd(12'h008, 32'h0000_0020, 1'b0);
    supply_ok <= 1'b1;
    wait_rel(120);
    cyc(2);
    rd(12'h008, 32'h0000_0000, 1'b0);
    wake_net <= 1'b1;
    supply_ok <= 1'b0;
    cyc(4);
    supply_ok <= 1'b1;
    wait_rel(4500);
    wake_net <= 1'b0;
    $display("test delay done");
  endtask
  initial
  begin
    cyc(8);
    presetn <= 1'b1;
    wait_rel(4500);
    t_regs();
    t_pins();
    t_irq();
    t_delay();
    close_out();
  end
endmodule
